// ===== design/asd_consts.svh
// Opcode patterns, field positions and clock counts of the arithmetic decoder
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH

// Single-byte opcodes
`define ASD_SEG_CODE 8'h2E
`define ASD_SEG_EXTRA 8'h26
`define ASD_SEG_STACK 8'h36
`define ASD_SEG_DATA 8'h3E
`define ASD_ASCII_SUM 8'h37
`define ASD_BCD_SUM 8'h27
`define ASD_ASCII_DIFF 8'h3F
`define ASD_BCD_DIFF 8'h2F

// Grouped opcodes and their masks
`define ASD_MASK_DW 8'hFC
`define ASD_MASK_W 8'hFE
`define ASD_MASK_REG 8'hF8
`define ASD_RM_SUM 8'h00
`define ASD_RM_CARRY 8'h10
`define ASD_RM_BORROW 8'h18
`define ASD_RM_DIFF 8'h28
`define ASD_RM_CMP 8'h38
`define ASD_ACC_SUM 8'h04
`define ASD_ACC_CARRY 8'h14
`define ASD_ACC_BORROW 8'h1C
`define ASD_ACC_DIFF 8'h2C
`define ASD_ACC_CMP 8'h3C
`define ASD_IMM_GRP 8'h80
`define ASD_STEP_GRP 8'hFE
`define ASD_UNARY_GRP 8'hF6
`define ASD_SHORT_INC 8'h40
`define ASD_SHORT_DEC 8'h48

// Reg field codes inside the groups
`define ASD_REG_SUM 3'h0
`define ASD_REG_CARRY 3'h2
`define ASD_REG_BORROW 3'h3
`define ASD_REG_DIFF 3'h5
`define ASD_REG_CMP 3'h7
`define ASD_REG_INC 3'h0
`define ASD_REG_DEC 3'h1
`define ASD_REG_NEG 3'h3
`define ASD_REG_MUL 3'h4

// Field positions
`define ASD_W_BIT 0
`define ASD_S_BIT 1
`define ASD_MOD_MSB 7
`define ASD_MOD_LSB 6
`define ASD_REG_MSB 5
`define ASD_REG_LSB 3
`define ASD_RM_MSB 2
`define ASD_RM_LSB 0
`define ASD_MOD_REGS 2'h3
`define ASD_MOD_D8 2'h1
`define ASD_MOD_D16 2'h2
`define ASD_MOD_NONE 2'h0
`define ASD_RM_DIRECT 3'h6
`define ASD_SW_WIDE 2'h1

// Clock counts
`define ASD_CK_PREFIX 6'h02
`define ASD_CK_RM_REG 6'h03
`define ASD_CK_RM_MEM 6'h0A
`define ASD_CK_IMM_REG 6'h04
`define ASD_CK_IMM_MEM 6'h10
`define ASD_CK_ACC_BYTE 6'h03
`define ASD_CK_ACC_WORD 6'h04
`define ASD_CK_STEP_REG 6'h03
`define ASD_CK_STEP_MEM 6'h0F
`define ASD_CK_SHORT 6'h03
`define ASD_CK_ASCII_SUM 6'h08
`define ASD_CK_BCD_FIX 6'h04
`define ASD_CK_ASCII_DIFF 6'h07
`define ASD_CK_MUL_RB_MIN 6'h1A
`define ASD_CK_MUL_RB_MAX 6'h1C
`define ASD_CK_MUL_RW_MIN 6'h23
`define ASD_CK_MUL_RW_MAX 6'h25
`define ASD_CK_MUL_MB_MIN 6'h20
`define ASD_CK_MUL_MB_MAX 6'h22
`define ASD_CK_MUL_MW_MIN 6'h29
`define ASD_CK_MUL_MW_MAX 6'h2B
`define ASD_CK_WORD_MEM 6'h04
`define ASD_CK_ONE 6'h01

`endif

// ===== design/asd_pkg.sv
// Types shared by the arithmetic decoder modules
`default_nettype none
package asd_pkg;

  typedef enum logic [3:0] {
    ASD_OP_NONE = 4'h0,
    ASD_OP_PREFIX = 4'h1,
    ASD_OP_SUM = 4'h2,
    ASD_OP_CARRY_SUM = 4'h3,
    ASD_OP_DIFF = 4'h4,
    ASD_OP_BORROW_DIFF = 4'h5,
    ASD_OP_COMPARISON = 4'h6,
    ASD_OP_PLUS_ONE = 4'h7,
    ASD_OP_MINUS_ONE = 4'h8,
    ASD_OP_SIGN_INVERT = 4'h9,
    ASD_OP_ASCII_SUM_FIX = 4'hA,
    ASD_OP_BCD_SUM_FIX = 4'hB,
    ASD_OP_ASCII_DIFF_FIX = 4'hC,
    ASD_OP_BCD_DIFF_FIX = 4'hD,
    ASD_OP_PRODUCT = 4'hE
  } asd_op_t;

  typedef enum logic [2:0] {
    ASD_FORM_SINGLE = 3'h0,
    ASD_FORM_RM = 3'h1,
    ASD_FORM_IMM_RM = 3'h2,
    ASD_FORM_ACC = 3'h3,
    ASD_FORM_SHORT = 3'h4,
    ASD_FORM_GROUP = 3'h5
  } asd_form_t;

  typedef enum logic [1:0] {
    ASD_SEG_NONE_T = 2'h0,
    ASD_SEG_CODE_T = 2'h1,
    ASD_SEG_STACK_T = 2'h2,
    ASD_SEG_DATA_T = 2'h3
  } asd_seg_t;

  typedef enum logic [3:0] {
    ASD_ST_OPCODE = 4'h0,
    ASD_ST_MODRM = 4'h1,
    ASD_ST_DISP_LO = 4'h2,
    ASD_ST_DISP_HI = 4'h3,
    ASD_ST_IMM_LO = 4'h4,
    ASD_ST_IMM_HI = 4'h5,
    ASD_ST_ISSUE = 4'h6,
    ASD_ST_EXEC = 4'h7
  } asd_state_t;

endpackage : asd_pkg
`default_nettype wire

// ===== design/asd_timing_if.sv
// Request and answer of the clock count lookup
`default_nettype none
interface asd_timing_if;
  import asd_pkg::*;
  asd_op_t op;
  asd_form_t form;
  logic word;
  logic mem;
  logic [5:0] clk_min;
  logic [5:0] clk_max;
  modport requester (output op, output form, output word, output mem, input clk_min, input clk_max);
  modport lookup (input op, input form, input word, input mem, output clk_min, output clk_max);
endinterface : asd_timing_if
`default_nettype wire

// ===== design/asd_clock_table.sv
// Clock count lookup for decoded arithmetic instructions
`include "asd_consts.svh"
`default_nettype none
module asd_clock_table
  import asd_pkg::*;
(
  asd_timing_if.lookup tif
);

  logic [5:0] base_min;
  logic [5:0] base_max;

  always_comb begin
    base_min = `ASD_CK_ONE;
    base_max = `ASD_CK_ONE;
    case (tif.op)
      ASD_OP_PREFIX: begin
        base_min = `ASD_CK_PREFIX;
      end
      ASD_OP_ASCII_SUM_FIX: begin
        base_min = `ASD_CK_ASCII_SUM;
      end
      ASD_OP_BCD_SUM_FIX, ASD_OP_BCD_DIFF_FIX: begin
        base_min = `ASD_CK_BCD_FIX;
      end
      ASD_OP_ASCII_DIFF_FIX: begin
        base_min = `ASD_CK_ASCII_DIFF;
      end
      ASD_OP_PLUS_ONE, ASD_OP_MINUS_ONE: begin
        if (tif.form == ASD_FORM_SHORT) begin
          base_min = `ASD_CK_SHORT;
        end else begin
          base_min = tif.mem ? `ASD_CK_STEP_MEM : `ASD_CK_STEP_REG;
        end
      end
      ASD_OP_SIGN_INVERT: begin
        base_min = tif.mem ? `ASD_CK_RM_MEM : `ASD_CK_RM_REG;
      end
      ASD_OP_PRODUCT: begin
        if (tif.mem) begin
          base_min = tif.word ? `ASD_CK_MUL_MW_MIN : `ASD_CK_MUL_MB_MIN;
          base_max = tif.word ? `ASD_CK_MUL_MW_MAX : `ASD_CK_MUL_MB_MAX;
        end else begin
          base_min = tif.word ? `ASD_CK_MUL_RW_MIN : `ASD_CK_MUL_RB_MIN;
          base_max = tif.word ? `ASD_CK_MUL_RW_MAX : `ASD_CK_MUL_RB_MAX;
        end
      end
      ASD_OP_NONE: begin
        base_min = `ASD_CK_ONE;
      end
      default: begin
        if (tif.form == ASD_FORM_ACC) begin
          base_min = tif.word ? `ASD_CK_ACC_WORD : `ASD_CK_ACC_BYTE;
        end else if (tif.form == ASD_FORM_IMM_RM && tif.op != ASD_OP_COMPARISON) begin
          base_min = tif.mem ? `ASD_CK_IMM_MEM : `ASD_CK_IMM_REG;
        end else begin
          base_min = tif.mem ? `ASD_CK_RM_MEM : `ASD_CK_RM_REG;
        end
      end
    endcase
    if (tif.op != ASD_OP_PRODUCT) begin
      base_max = base_min;
    end
  end

  assign tif.clk_min = (tif.mem && tif.word) ? base_min + `ASD_CK_WORD_MEM : base_min;
  assign tif.clk_max = (tif.mem && tif.word) ? base_max + `ASD_CK_WORD_MEM : base_max;

endmodule : asd_clock_table
`default_nettype wire

// ===== design/asd_decoder.sv
// Arithmetic and segment prefix decoder with execution clock counting
// Overview of operation
// - Bytes 2E, 36, 3E override code, stack, data segment; two clocks each.
// - Sum between register-or-memory and register: 3 clocks register, 10 memory.
// - Carry sum decodes from 000100dw, group reg 010, and 0001010w.
// - Difference decodes from 001010dw and 0010110w; accumulator form 3 or 4 clocks.
// - Borrow difference from 000110dw, group reg 011, 0001110w; immediate 4/16 clocks.
// - Comparison from 0011101w, 0011100w, 0011110w; 3 clocks register (word accumulator 4), 10 memory.
// - Minus one from 1111111w reg 001 takes 3/15; short 01001reg takes 3.
// - Sign invert from 1111011w reg 011 takes 3 register, 10 memory.
// - ASCII sum fixup is byte 00110111, 8 clocks.
// - Packed sum fixup is byte 00100111, 4 clocks.
// - ASCII difference fixup is byte 00111111, 7 clocks.
// - Packed difference fixup is byte 00101111, 4 clocks.
// - Product from 1111011w reg 100 with ranges by operand width and place.
// - Word memory transfers add 4 clocks to every memory count, product ranges included.
`include "asd_consts.svh"
`default_nettype none
module asd_decoder
  import asd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  output logic instr_valid,
  output logic instr_bad,
  output asd_op_t instr_op,
  output asd_form_t instr_form,
  output logic instr_word,
  output logic instr_mem,
  output asd_seg_t instr_seg,
  output logic [15:0] instr_imm,
  output logic [5:0] instr_clk_min,
  output logic [5:0] instr_clk_max,
  output logic exec_busy,
  output logic exec_done
);

  asd_timing_if tif ();

  asd_state_t state_reg, state_next;
  asd_op_t op_reg, op_next;
  asd_form_t form_reg, form_next;
  logic word_reg, word_next;
  logic sign_reg, sign_next;
  logic mem_reg, mem_next;
  logic bad_reg, bad_next;
  logic imm_two_reg, imm_two_next;
  logic imm_any_reg, imm_any_next;
  logic [7:0] opc_reg, opc_next;
  asd_seg_t seg_reg, seg_next;
  logic [15:0] imm_reg, imm_next;
  logic [5:0] count_reg, count_next;
  logic valid_reg, valid_next;
  logic ibad_reg, ibad_next;
  logic done_reg, done_next;
  asd_op_t out_op_reg, out_op_next;
  asd_form_t out_form_reg, out_form_next;
  logic out_word_reg, out_word_next;
  logic out_mem_reg, out_mem_next;
  asd_seg_t out_seg_reg, out_seg_next;
  logic [15:0] out_imm_reg, out_imm_next;
  logic [5:0] out_min_reg, out_min_next;
  logic [5:0] out_max_reg, out_max_next;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic match(input logic [7:0] b, input logic [7:0] mask, input logic [7:0] pat);
    match = (b & mask) == pat;
  endfunction : match

  function automatic logic [2:0] reg_field(input logic [7:0] b);
    reg_field = b[`ASD_REG_MSB:`ASD_REG_LSB];
  endfunction : reg_field

  function automatic asd_op_t rm_op(input logic [7:0] b);
    rm_op = ASD_OP_NONE;
    if (match(b, `ASD_MASK_DW, `ASD_RM_SUM) || match(b, `ASD_MASK_W, `ASD_ACC_SUM)) begin
      rm_op = ASD_OP_SUM;
    end else if (match(b, `ASD_MASK_DW, `ASD_RM_CARRY) || match(b, `ASD_MASK_W, `ASD_ACC_CARRY)) begin
      rm_op = ASD_OP_CARRY_SUM;
    end else if (match(b, `ASD_MASK_DW, `ASD_RM_BORROW) || match(b, `ASD_MASK_W, `ASD_ACC_BORROW)) begin
      rm_op = ASD_OP_BORROW_DIFF;
    end else if (match(b, `ASD_MASK_DW, `ASD_RM_DIFF) || match(b, `ASD_MASK_W, `ASD_ACC_DIFF)) begin
      rm_op = ASD_OP_DIFF;
    end else if (match(b, `ASD_MASK_DW, `ASD_RM_CMP) || match(b, `ASD_MASK_W, `ASD_ACC_CMP)) begin
      rm_op = ASD_OP_COMPARISON;
    end
  endfunction : rm_op

  // ****************************************
  // Clock count lookup
  // ****************************************
  assign tif.op = op_reg;
  assign tif.form = form_reg;
  assign tif.word = word_reg;
  assign tif.mem = mem_reg;

  asd_clock_table u_table (
    .tif(tif)
  );

  // ****************************************
  // Byte collection and execution timing
  // ****************************************
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    form_next = form_reg;
    word_next = word_reg;
    sign_next = sign_reg;
    mem_next = mem_reg;
    bad_next = bad_reg;
    imm_two_next = imm_two_reg;
    imm_any_next = imm_any_reg;
    opc_next = opc_reg;
    seg_next = seg_reg;
    imm_next = imm_reg;
    count_next = count_reg;
    valid_next = 1'b0;
    ibad_next = 1'b0;
    done_next = 1'b0;
    out_op_next = out_op_reg;
    out_form_next = out_form_reg;
    out_word_next = out_word_reg;
    out_mem_next = out_mem_reg;
    out_seg_next = out_seg_reg;
    out_imm_next = out_imm_reg;
    out_min_next = out_min_reg;
    out_max_next = out_max_reg;
    case (state_reg)
      ASD_ST_OPCODE: begin
        if (byte_valid) begin
          opc_next = byte_data;
          word_next = byte_data[`ASD_W_BIT];
          sign_next = byte_data[`ASD_S_BIT];
          mem_next = 1'b0;
          bad_next = 1'b0;
          imm_next = 16'h0000;
          imm_any_next = 1'b0;
          imm_two_next = 1'b0;
          op_next = rm_op(byte_data);
          form_next = ASD_FORM_SINGLE;
          state_next = ASD_ST_ISSUE;
          if (byte_data == `ASD_SEG_CODE || byte_data == `ASD_SEG_STACK || byte_data == `ASD_SEG_DATA
              || byte_data == `ASD_SEG_EXTRA) begin
            op_next = ASD_OP_PREFIX;
            word_next = 1'b0;
          end else if (byte_data == `ASD_ASCII_SUM) begin
            op_next = ASD_OP_ASCII_SUM_FIX;
            word_next = 1'b0;
          end else if (byte_data == `ASD_BCD_SUM) begin
            op_next = ASD_OP_BCD_SUM_FIX;
            word_next = 1'b0;
          end else if (byte_data == `ASD_ASCII_DIFF) begin
            op_next = ASD_OP_ASCII_DIFF_FIX;
            word_next = 1'b0;
          end else if (byte_data == `ASD_BCD_DIFF) begin
            op_next = ASD_OP_BCD_DIFF_FIX;
            word_next = 1'b0;
          end else if (match(byte_data, `ASD_MASK_REG, `ASD_SHORT_INC)
                       || match(byte_data, `ASD_MASK_REG, `ASD_SHORT_DEC)) begin
            op_next = match(byte_data, `ASD_MASK_REG, `ASD_SHORT_DEC) ? ASD_OP_MINUS_ONE : ASD_OP_PLUS_ONE;
            form_next = ASD_FORM_SHORT;
            word_next = 1'b1;
          end else if (match(byte_data, `ASD_MASK_DW, `ASD_IMM_GRP)) begin
            form_next = ASD_FORM_IMM_RM;
            imm_any_next = 1'b1;
            // Second data byte only for s,w of 01
            imm_two_next = byte_data[`ASD_S_BIT:`ASD_W_BIT] == `ASD_SW_WIDE;
            state_next = ASD_ST_MODRM;
          end else if (match(byte_data, `ASD_MASK_W, `ASD_STEP_GRP)
                       || match(byte_data, `ASD_MASK_W, `ASD_UNARY_GRP)) begin
            form_next = ASD_FORM_GROUP;
            state_next = ASD_ST_MODRM;
          end else if (rm_op(byte_data) != ASD_OP_NONE && byte_data[2]) begin
            form_next = ASD_FORM_ACC;
            imm_any_next = 1'b1;
            imm_two_next = byte_data[`ASD_W_BIT];
            state_next = ASD_ST_IMM_LO;
          end else if (rm_op(byte_data) != ASD_OP_NONE) begin
            form_next = ASD_FORM_RM;
            state_next = ASD_ST_MODRM;
          end else begin
            bad_next = 1'b1;
          end
        end
      end
      ASD_ST_MODRM: begin
        if (byte_valid) begin
          mem_next = byte_data[`ASD_MOD_MSB:`ASD_MOD_LSB] != `ASD_MOD_REGS;
          if (form_reg == ASD_FORM_IMM_RM) begin
            case (reg_field(byte_data))
              `ASD_REG_SUM: op_next = ASD_OP_SUM;
              `ASD_REG_CARRY: op_next = ASD_OP_CARRY_SUM;
              `ASD_REG_BORROW: op_next = ASD_OP_BORROW_DIFF;
              `ASD_REG_DIFF: op_next = ASD_OP_DIFF;
              `ASD_REG_CMP: op_next = ASD_OP_COMPARISON;
              default: bad_next = 1'b1;
            endcase
          end else if (form_reg == ASD_FORM_GROUP) begin
            form_next = ASD_FORM_RM;
            if (match(opc_reg, `ASD_MASK_W, `ASD_STEP_GRP) && reg_field(byte_data) == `ASD_REG_INC) begin
              op_next = ASD_OP_PLUS_ONE;
            end else if (match(opc_reg, `ASD_MASK_W, `ASD_STEP_GRP) && reg_field(byte_data) == `ASD_REG_DEC) begin
              op_next = ASD_OP_MINUS_ONE;
            end else if (match(opc_reg, `ASD_MASK_W, `ASD_UNARY_GRP) && reg_field(byte_data) == `ASD_REG_NEG) begin
              op_next = ASD_OP_SIGN_INVERT;
            end else if (match(opc_reg, `ASD_MASK_W, `ASD_UNARY_GRP) && reg_field(byte_data) == `ASD_REG_MUL) begin
              op_next = ASD_OP_PRODUCT;
            end else begin
              bad_next = 1'b1;
            end
          end
          if (byte_data[`ASD_MOD_MSB:`ASD_MOD_LSB] == `ASD_MOD_D8) begin
            state_next = ASD_ST_DISP_HI;
          end else if (byte_data[`ASD_MOD_MSB:`ASD_MOD_LSB] == `ASD_MOD_D16
                       || (byte_data[`ASD_MOD_MSB:`ASD_MOD_LSB] == `ASD_MOD_NONE
                           && byte_data[`ASD_RM_MSB:`ASD_RM_LSB] == `ASD_RM_DIRECT)) begin
            state_next = ASD_ST_DISP_LO;
          end else begin
            state_next = imm_any_reg ? ASD_ST_IMM_LO : ASD_ST_ISSUE;
          end
        end
      end
      ASD_ST_DISP_LO: begin
        if (byte_valid) begin
          state_next = ASD_ST_DISP_HI;
        end
      end
      ASD_ST_DISP_HI: begin
        if (byte_valid) begin
          state_next = imm_any_reg ? ASD_ST_IMM_LO : ASD_ST_ISSUE;
        end
      end
      ASD_ST_IMM_LO: begin
        if (byte_valid) begin
          // Sign extension of a single byte
          imm_next = {(word_reg && sign_reg && byte_data[7]) ? 8'hFF : 8'h00, byte_data};
          state_next = imm_two_reg ? ASD_ST_IMM_HI : ASD_ST_ISSUE;
        end
      end
      ASD_ST_IMM_HI: begin
        if (byte_valid) begin
          imm_next = {byte_data, imm_reg[7:0]};
          state_next = ASD_ST_ISSUE;
        end
      end
      ASD_ST_ISSUE: begin
        valid_next = !bad_reg;
        ibad_next = bad_reg;
        out_op_next = bad_reg ? ASD_OP_NONE : op_reg;
        out_form_next = form_reg;
        out_word_next = word_reg;
        out_mem_next = mem_reg;
        out_seg_next = seg_reg;
        out_imm_next = imm_reg;
        out_min_next = tif.clk_min;
        out_max_next = tif.clk_max;
        count_next = tif.clk_min - `ASD_CK_ONE;
        // Override held for the following instruction
        if (op_reg == ASD_OP_PREFIX) begin
          if (opc_reg == `ASD_SEG_CODE) begin
            seg_next = ASD_SEG_CODE_T;
          end else if (opc_reg == `ASD_SEG_STACK) begin
            seg_next = ASD_SEG_STACK_T;
          end else if (opc_reg == `ASD_SEG_DATA) begin
            seg_next = ASD_SEG_DATA_T;
          end else begin
            seg_next = ASD_SEG_NONE_T;
          end
        end else begin
          seg_next = ASD_SEG_NONE_T;
        end
        if (bad_reg) begin
          state_next = ASD_ST_OPCODE;
        end else begin
          state_next = ASD_ST_EXEC;
        end
      end
      ASD_ST_EXEC: begin
        if (count_reg == `ASD_CK_ONE) begin
          done_next = 1'b1;
          state_next = ASD_ST_OPCODE;
        end
        count_next = count_reg - `ASD_CK_ONE;
      end
      default: begin
        state_next = ASD_ST_OPCODE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ASD_ST_OPCODE;
      op_reg <= ASD_OP_NONE;
      form_reg <= ASD_FORM_SINGLE;
      word_reg <= 1'b0;
      sign_reg <= 1'b0;
      mem_reg <= 1'b0;
      bad_reg <= 1'b0;
      imm_two_reg <= 1'b0;
      imm_any_reg <= 1'b0;
      opc_reg <= 8'h00;
      seg_reg <= ASD_SEG_NONE_T;
      imm_reg <= 16'h0000;
      count_reg <= 6'h00;
      valid_reg <= 1'b0;
      ibad_reg <= 1'b0;
      done_reg <= 1'b0;
      out_op_reg <= ASD_OP_NONE;
      out_form_reg <= ASD_FORM_SINGLE;
      out_word_reg <= 1'b0;
      out_mem_reg <= 1'b0;
      out_seg_reg <= ASD_SEG_NONE_T;
      out_imm_reg <= 16'h0000;
      out_min_reg <= 6'h00;
      out_max_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      form_reg <= form_next;
      word_reg <= word_next;
      sign_reg <= sign_next;
      mem_reg <= mem_next;
      bad_reg <= bad_next;
      imm_two_reg <= imm_two_next;
      imm_any_reg <= imm_any_next;
      opc_reg <= opc_next;
      seg_reg <= seg_next;
      imm_reg <= imm_next;
      count_reg <= count_next;
      valid_reg <= valid_next;
      ibad_reg <= ibad_next;
      done_reg <= done_next;
      out_op_reg <= out_op_next;
      out_form_reg <= out_form_next;
      out_word_reg <= out_word_next;
      out_mem_reg <= out_mem_next;
      out_seg_reg <= out_seg_next;
      out_imm_reg <= out_imm_next;
      out_min_reg <= out_min_next;
      out_max_reg <= out_max_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign byte_ready = state_reg != ASD_ST_ISSUE && state_reg != ASD_ST_EXEC;
  assign exec_busy = state_reg == ASD_ST_EXEC;
  assign instr_valid = valid_reg;
  assign instr_bad = ibad_reg;
  assign exec_done = done_reg;
  assign instr_op = out_op_reg;
  assign instr_form = out_form_reg;
  assign instr_word = out_word_reg;
  assign instr_mem = out_mem_reg;
  assign instr_seg = out_seg_reg;
  assign instr_imm = out_imm_reg;
  assign instr_clk_min = out_min_reg;
  assign instr_clk_max = out_max_reg;

endmodule : asd_decoder
`default_nettype wire

// ===== bench/asd_checker.sv
// Timing checks at the ports of the arithmetic decoder
`default_nettype none
module asd_checker
  import asd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic byte_ready,
  input wire logic instr_valid,
  input wire logic instr_bad,
  input wire asd_op_t instr_op,
  input wire asd_form_t instr_form,
  input wire logic instr_word,
  input wire logic instr_mem,
  input wire asd_seg_t instr_seg,
  input wire logic [15:0] instr_imm,
  input wire logic [5:0] instr_clk_min,
  input wire logic [5:0] instr_clk_max,
  input wire logic exec_busy,
  input wire logic exec_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] busy_reg;
  logic [5:0] busy_next;
  logic iv;
  assign iv = instr_valid;
  // Counts busy cycles of the current execution
  always_comb busy_next = exec_busy ? busy_reg + 6'h01 : 6'h00;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) busy_reg <= 6'h00;
    else busy_reg <= busy_next;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  prefix_clk_a: assert property (iv && instr_op == ASD_OP_PREFIX |-> instr_clk_min == 6'h02)
    else $error("prefix count wrong");
  sum_clk_a: assert property (iv && instr_op == ASD_OP_SUM && instr_form == ASD_FORM_RM
    |-> instr_clk_min == (!instr_mem ? 6'h03 : instr_word ? 6'h0E : 6'h0A)) else $error("sum count wrong");
  acc_clk_a: assert property (iv && instr_form == ASD_FORM_ACC |-> instr_clk_min == (instr_word ? 6'h04 : 6'h03))
    else $error("accumulator count wrong");
  short_clk_a: assert property (iv && instr_form == ASD_FORM_SHORT |-> instr_clk_min == 6'h03)
    else $error("short form count wrong");
  ascii_decode_a: assert property (iv && instr_op == ASD_OP_ASCII_SUM_FIX
    |-> $past(byte_data, 2) == 8'h37 && instr_clk_min == 6'h08) else $error("ascii sum decode wrong");
  bcd_clk_a: assert property (iv && instr_op inside {ASD_OP_BCD_SUM_FIX, ASD_OP_BCD_DIFF_FIX}
    |-> instr_clk_min == 6'h04) else $error("packed fixup count wrong");
  product_clk_a: assert property (iv && instr_op == ASD_OP_PRODUCT && !instr_mem && !instr_word
    |-> instr_clk_min == 6'h1A && instr_clk_max == 6'h1C) else $error("product range wrong");
  busy_len_a: assert property (exec_done |-> busy_reg == instr_clk_min - 6'h01)
    else $error("execution length wrong");
  busy_refuse_a: assert property (exec_busy |-> !byte_ready ##1 !(instr_valid || instr_bad))
    else $error("byte accepted while busy");
endmodule : asd_checker
`default_nettype wire

// ===== bench/asd_queue_model.sv
// Prefetch queue model offering opcode bytes
`default_nettype none
module asd_queue_model (
  input wire logic core_clk,
  input wire logic stall,
  input wire logic byte_ready,
  output var logic byte_valid,
  output var logic [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] q[$];
  logic taken, hold;
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  // Holds an offer until taken; idle data toggles
  always @(posedge core_clk) begin
    taken = byte_valid && byte_ready;
    hold = stall;
    #1;
    if (taken) void'(q.pop_front());
    if (!byte_valid || taken) begin
      byte_valid = q.size() > 0 && !hold;
      byte_data = byte_valid ? q[0] : ~byte_data;
    end
  end
endmodule : asd_queue_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench of the arithmetic decoder
`default_nettype none
module testbench
  import asd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rst_n = 1'b0, stall = 1'b0, byte_ready, byte_valid, instr_valid, instr_bad, word, mem;
  logic exec_busy, exec_done;
  logic [7:0] byte_data;
  logic [15:0] instr_imm;
  logic [5:0] cmin, cmax;
  logic [31:0] r;
  asd_op_t instr_op;
  asd_form_t form;
  asd_seg_t seg;
  int errors = 0, cmp_count = 0, i;
  integer seed = 32'hF8BA4CDA;
  logic [7:0] base[5] = '{8'h00, 8'h10, 8'h28, 8'h18, 8'h38};
  asd_op_t bop[5] = '{ASD_OP_SUM, ASD_OP_CARRY_SUM, ASD_OP_DIFF, ASD_OP_BORROW_DIFF, ASD_OP_COMPARISON};
  always #12.5 core_clk = ~core_clk;
  asd_decoder dut (.core_clk(core_clk), .rst_n(rst_n), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(byte_ready), .instr_valid(instr_valid), .instr_bad(instr_bad), .instr_op(instr_op),
    .instr_form(form), .instr_word(word), .instr_mem(mem), .instr_seg(seg), .instr_imm(instr_imm),
    .instr_clk_min(cmin), .instr_clk_max(cmax), .exec_busy(exec_busy), .exec_done(exec_done));
  asd_queue_model queue (.core_clk(core_clk), .stall(stall), .byte_ready(byte_ready), .byte_valid(byte_valid),
    .byte_data(byte_data));
  always @(posedge core_clk) #1 stall = ($random(seed) & 3) == 0;
  function automatic logic [5:0] rm_clk(input logic [7:0] opc, input logic [7:0] mrm);
    return mrm[7:6] == 2'h3 ? 6'h03 : (opc[0] ? 6'h0E : 6'h0A);
  endfunction : rm_clk
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic run(input int n, input logic [31:0] b, input asd_op_t op, input logic [5:0] lo, input logic [5:0] hi);
    int k;
    for (k = 0; k < n; k++) queue.q.push_back(b[8*k +: 8]);
    k = 0;
    do begin
      @(posedge core_clk);
      #2;
      k++;
    end while (instr_valid !== 1'b1 && instr_bad !== 1'b1 && k < 300);
    check(k < 300, 1'b1);
    check(instr_bad, op == ASD_OP_NONE);
    check(instr_op, op);
    if (op != ASD_OP_NONE) begin
      check(cmin, lo);
      check(cmax, hi);
      k = 0;
      while (exec_done !== 1'b1 && k < 100) begin
        @(posedge core_clk);
        #2;
        k++;
      end
      check(k, lo - 6'h01);
    end
    $display("test done op %0d bytes %h", op, b);
  endtask : run
  initial begin
    #1000000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    run(1, 32'h2E, ASD_OP_PREFIX, 6'h02, 6'h02);
    run(1, 32'h37, ASD_OP_ASCII_SUM_FIX, 6'h08, 6'h08);
    check(seg, ASD_SEG_CODE_T);
    run(1, 32'h36, ASD_OP_PREFIX, 6'h02, 6'h02);
    run(1, 32'h27, ASD_OP_BCD_SUM_FIX, 6'h04, 6'h04);
    check(seg, ASD_SEG_STACK_T);
    run(1, 32'h3E, ASD_OP_PREFIX, 6'h02, 6'h02);
    run(1, 32'h3F, ASD_OP_ASCII_DIFF_FIX, 6'h07, 6'h07);
    check(seg, ASD_SEG_DATA_T);
    run(1, 32'h26, ASD_OP_PREFIX, 6'h02, 6'h02);
    run(1, 32'h2F, ASD_OP_BCD_DIFF_FIX, 6'h04, 6'h04);
    check(seg, ASD_SEG_NONE_T);
    run(3, 32'hFFD083, ASD_OP_CARRY_SUM, 6'h04, 6'h04);
    check(instr_imm, 16'hFFFF);
    run(4, 32'h1234D881, ASD_OP_BORROW_DIFF, 6'h04, 6'h04);
    check(instr_imm, 16'h1234);
    run(3, 32'h05E880, ASD_OP_DIFF, 6'h04, 6'h04);
    run(3, 32'h013883, ASD_OP_COMPARISON, 6'h0E, 6'h0E);
    run(3, 32'h00C880, ASD_OP_NONE, 6'h00, 6'h00);
    run(1, 32'h0F, ASD_OP_NONE, 6'h00, 6'h00);
    run(3, 32'h12342D, ASD_OP_DIFF, 6'h04, 6'h04);
    run(2, 32'h0714, ASD_OP_CARRY_SUM, 6'h03, 6'h03);
    run(3, 32'h00011D, ASD_OP_BORROW_DIFF, 6'h04, 6'h04);
    run(2, 32'h093C, ASD_OP_COMPARISON, 6'h03, 6'h03);
    run(4, 32'h10000EFF, ASD_OP_MINUS_ONE, 6'h13, 6'h13);
    run(1, 32'h49, ASD_OP_MINUS_ONE, 6'h03, 6'h03);
    run(1, 32'h40, ASD_OP_PLUS_ONE, 6'h03, 6'h03);
    run(4, 32'h10001EF7, ASD_OP_SIGN_INVERT, 6'h0E, 6'h0E);
    run(2, 32'hE0F6, ASD_OP_PRODUCT, 6'h1A, 6'h1C);
    run(3, 32'h0066F6, ASD_OP_PRODUCT, 6'h20, 6'h22);
    run(4, 32'h100026F7, ASD_OP_PRODUCT, 6'h2D, 6'h2F);
    repeat (40) begin
      r = $random(seed);
      i = r[31:8] % 5;
      run(r[7:6] == 2'h3 ? 2 : r[7:6] == 2'h1 ? 3 : (r[7:6] == 2'h2 || r[2:0] == 3'h6) ? 4 : 2,
        {r[31:16], r[7:0], base[i] | r[9:8]}, bop[i], rm_clk(r[15:8], r[7:0]), rm_clk(r[15:8], r[7:0]));
    end
    #1 rst_n = 1'b0;
    #30 check(instr_op, ASD_OP_NONE);
    @(posedge core_clk) #1 rst_n = 1'b1;
    run(2, 32'hD8F6, ASD_OP_SIGN_INVERT, 6'h03, 6'h03);
    summarize();
  end
endmodule : testbench
bind asd_decoder asd_checker chk (.core_clk(core_clk), .rst_n(rst_n), .byte_valid(byte_valid),
  .byte_data(byte_data), .byte_ready(byte_ready), .instr_valid(instr_valid), .instr_bad(instr_bad),
  .instr_op(instr_op), .instr_form(instr_form), .instr_word(instr_word), .instr_mem(instr_mem),
  .instr_seg(instr_seg), .instr_imm(instr_imm), .instr_clk_min(instr_clk_min), .instr_clk_max(instr_clk_max),
  .exec_busy(exec_busy), .exec_done(exec_done));
`default_nettype wire
